// [bench/ncr_dev_model.sv]
// behavioural nand device answering the host controller
`timescale 1ns/10ps
`default_nettype none
module ncr_dev_model #(
   parameter int          BUSY_NS  = 120,
   parameter int          CACHE_NS = 60,
   parameter int          HOLD_NS  = 8,
   parameter logic [7:0]  MFR_CODE = 8'h3C,       // arbitrary value
   parameter logic [7:0]  DEV_CODE = 8'h5A,       // arbitrary value
   parameter logic [31:0] SIG      = 32'h1A2B3C4D // arbitrary value
) (
   input  wire logic       chip_en_n,
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic [7:0] io_out,
   output logic      [7:0] io_in,
   output logic            ready_busy_n
);
   logic [31:0] addr;
   logic [15:0] cache_pg, data_pg;
   logic [11:0] col;
   logic [7:0]  last_cmd, status;
   logic        id_mode, id_alt;
   int          acnt, id_idx;
   function automatic logic [7:0] pat(logic [15:0] p, logic [11:0] c);
      return p[7:0] ^ c[7:0] ^ {c[11:8], 4'h0};
   endfunction
   function automatic logic [7:0] idb(logic alt, int i);
      logic [7:0] t [5];
      t = '{MFR_CODE, DEV_CODE, 8'h80, 8'h15, 8'h00};
      return alt ? SIG[8*(3-i%4) +: 8] : t[i%5];
   endfunction
   task automatic go_busy(int ns, logic [1:0] bits);
      ready_busy_n = 1'b0;
      status[6:5] = 2'h0;
      #(ns);
      ready_busy_n = 1'b1;
      status[6:5] = bits;
   endtask
   initial begin
      io_in = 8'h00;
      ready_busy_n = 1'b1;
      status = 8'h60;
      acnt = 0;
      id_mode = 1'b0;
      last_cmd = 8'hFF;
   end
   //////////////////////////////////////////////////////////////////////////////
   always @(posedge write_strobe_n) begin
      if (!chip_en_n && addr_latch) begin
         addr[8*acnt +: 8] = io_out;
         acnt = acnt + 1;
         id_alt = (io_out == 8'h20);
         id_mode = (last_cmd == 8'h90);
         id_idx = 0;
      end else if (!chip_en_n && cmd_latch) begin
         id_mode = 1'b0;
         case (io_out)
            // row sits in cycles three and four; the column high cycle has 4 bits only
            8'h30: begin
               cache_pg = addr[31:16];
               data_pg = addr[31:16];
               fork go_busy(BUSY_NS, 2'h3); join_none
            end
            8'h31: begin
               cache_pg = data_pg;
               data_pg = (last_cmd == 8'h00 && acnt == 4) ?
                         addr[31:16] : data_pg + 16'h1;
               fork go_busy(CACHE_NS, 2'h2); join_none
            end
            8'h3F: begin
               cache_pg = data_pg;
               fork go_busy(CACHE_NS, 2'h3); join_none
            end
            default: ;
         endcase
         col = (io_out == 8'hE0) ? addr[11:0] : 12'h0;
         if (io_out == 8'h00 || io_out == 8'h05 || io_out == 8'h90) begin
            acnt = 0;
            addr = 32'h0;
         end
         last_cmd = io_out;
      end
   end
   always @(negedge read_strobe_n) begin
      if (!chip_en_n) io_in = id_mode ? idb(id_alt, id_idx) : pat(cache_pg, col);
   end
   // after the hold time the bus floats: show a changed value, never the old one
   always @(posedge read_strobe_n) begin
      if (!chip_en_n) begin
         if (id_mode) id_idx = id_idx + 1;
         else col = col + 12'h1;
         #(HOLD_NS);
         io_in = ~io_in;
      end
   end
endmodule
`default_nettype wire

// [bench/ncr_host_assertions.sv]
// concurrent checks on the pins of the nand host controller
`timescale 1ns/10ps
`default_nettype none
module ncr_host_assertions (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       done_pulse,
   input wire logic       chip_en_n,
   input wire logic       cmd_latch,
   input wire logic       addr_latch,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic [7:0] io_out,
   input wire logic       io_oe,
   input wire logic       ready_busy_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic [2:0] beat_q;
   // address beats since the last command beat
   always_ff @(posedge clock or posedge reset) begin
      if (reset) beat_q <= 3'h0;
      else if ($fell(write_strobe_n) && cmd_latch) beat_q <= 3'h0;
      else if ($fell(write_strobe_n) && addr_latch) beat_q <= beat_q + 3'h1;
   end
   //////////////////////////////////////////////////////////////////////////////
   sequence s_we_beat;
      (!write_strobe_n)[*3] ##1 write_strobe_n[*3];
   endsequence
   sequence s_re_beat;
      (!read_strobe_n)[*3] ##1 read_strobe_n[*3];
   endsequence
   property p_we_beat; $fell(write_strobe_n) |-> s_we_beat; endproperty
   property p_re_beat; $fell(read_strobe_n) |-> s_re_beat; endproperty
   property p_cmd_drive;
      !write_strobe_n |-> io_oe && !chip_en_n && (cmd_latch ^ addr_latch);
   endproperty
   property p_read_release;
      !read_strobe_n |-> !io_oe && !chip_en_n && !cmd_latch && !addr_latch;
   endproperty
   property p_col_hi;
      $fell(write_strobe_n) && addr_latch && beat_q == 3'h1 |-> io_out[7:4] == 4'h0;
   endproperty
   // busy means the device ignores the bus, so strobes must rest
   property p_busy_quiet; (!ready_busy_n)[*3] |-> write_strobe_n && read_strobe_n; endproperty
   property p_done_ready; done_pulse |-> ready_busy_n && $past(ready_busy_n); endproperty
   property p_re_ready; $fell(read_strobe_n) |-> ready_busy_n && $past(ready_busy_n, 2); endproperty
   a_we_beat: assert property (p_we_beat) else $error("write strobe beat not 3 low 3 high");
   a_re_beat: assert property (p_re_beat) else $error("read strobe beat not 3 low 3 high");
   a_cmd_drive: assert property (p_cmd_drive) else $error("write beat without drive");
   a_read_release: assert property (p_read_release) else $error("bus driven in read");
   a_col_hi: assert property (p_col_hi) else $error("column high nibble not low");
   a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while busy");
   a_done_ready: assert property (p_done_ready) else $error("done while busy");
   a_re_ready: assert property (p_re_ready) else $error("read before ready");
endmodule
bind ncr_host ncr_host_assertions u_chk (.clock(clock), .reset(reset), .done_pulse(done_pulse),
   .chip_en_n(chip_en_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
   .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
   .io_oe(io_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire

// [bench/ncr_host_bench.sv]
// self-checking bench for the nand host controller
`timescale 1ns/10ps
`default_nettype none
module ncr_host_bench;
   typedef struct {
      logic [2:0] op; logic [27:0] addr; logic [7:0] len; int n; int kind; logic [15:0] pg; logic [11:0] c0;
   } ncr_row_t;
   logic       clock, reset, cmd_valid, cmd_ready, rd_valid, rd_ready, done_pulse, chip_en_n;
   logic       cmd_latch, addr_latch, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
   logic [2:0] cmd_op;
   logic [27:0] cmd_addr;
   logic [7:0] cmd_len, rd_data, io_out, io_in;
   int         bad_count, total_checks, cyc;
   logic [7:0] got_q[$];
   ncr_row_t   rows[14];
   ncr_host DUT (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .done_pulse(done_pulse), .chip_en_n(chip_en_n),
      .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
      .ready_busy_n(ready_busy_n));
   ncr_dev_model dev (.chip_en_n(chip_en_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
      .io_in(io_in), .ready_busy_n(ready_busy_n));
   always #2.5 clock = ~clock;
   always @(posedge clock) if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);
   // one ceiling for the whole run; a hang ends in the report
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(logic [7:0] got, logic [7:0] exp, string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic do_cmd(logic [2:0] op, logic [27:0] a, logic [7:0] len);
      @(negedge clock);
      cmd_op = op;
      cmd_addr = a;
      cmd_len = len;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
      while (done_pulse !== 1'b1) @(negedge clock);
   endtask
   task automatic expect_bytes(int n, int kind, logic [15:0] pg, logic [11:0] c0);
      for (int k = 0; k < 50 && got_q.size() < n; k++) @(negedge clock);
      check(8'(got_q.size()), 8'(n), "byte count");
      for (int i = 0; i < n && got_q.size() > 0; i++)
         check(got_q.pop_front(), kind == 1 ? dev.pat(pg, c0 + 12'(i)) :
               dev.idb(kind == 3, int'(c0) + i), "byte");
      got_q.delete();
   endtask
   initial begin
      clock = 0; reset = 1; cmd_valid = 0; cmd_op = 0; cmd_addr = 0; cmd_len = 0; rd_ready = 1;
      bad_count = 0; total_checks = 0; cyc = 0;
      rows = '{'{3'h0, 28'h0003000, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h06, 6, 1, 16'h3, 0},
         '{3'h4, 28'h00037FE, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h02, 2, 1, 16'h3, 12'h7FE},
         '{3'h1, 0, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h03, 3, 1, 16'h3, 0},
         '{3'h1, 0, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h02, 2, 1, 16'h4, 0},
         '{3'h2, 28'h0009123, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h02, 2, 1, 16'h5, 0},
         '{3'h3, 0, 8'h00, 0, 0, 0, 0}, '{3'h7, 0, 8'h02, 2, 1, 16'h9, 0},
         '{3'h5, 0, 8'h00, 5, 2, 0, 0}, '{3'h6, 0, 8'h00, 4, 3, 0, 0}};
      repeat (3) @(negedge clock);
      check({chip_en_n, write_strobe_n, read_strobe_n, io_oe, cmd_latch, addr_latch, cmd_ready, rd_valid}, 8'hE0, "reset pins");
      repeat (3) @(negedge clock);
      reset = 0;
      foreach (rows[i]) begin
         do_cmd(rows[i].op, rows[i].addr, rows[i].len);
         expect_bytes(rows[i].n, rows[i].kind, rows[i].pg, rows[i].c0);
      end
      // stalled consumer: four more id bytes fill the fifo
      rd_ready = 0;
      do_cmd(3'h7, 0, 8'h04);
      repeat (4) @(negedge clock);
      check({7'h0, rd_valid}, 8'h01, "fifo holds data");
      check(8'(got_q.size()), 8'h00, "nothing taken while stalled");
      rd_ready = 1;
      expect_bytes(4, 3, 0, 12'h4);
      // reset in mid command, then a clean page read
      cmd_op = 3'h0;
      cmd_addr = 28'h0005000;
      cmd_valid = 1;
      repeat (8) @(negedge clock);
      cmd_valid = 0;
      reset = 1;
      @(negedge clock);
      check({chip_en_n, write_strobe_n, read_strobe_n, io_oe, cmd_latch, addr_latch, cmd_ready, rd_valid}, 8'hE0, "mid reset pins");
      reset = 0;
      while (ready_busy_n !== 1'b1) @(negedge clock);
      do_cmd(3'h0, 28'h0005000, 8'h00);
      do_cmd(3'h7, 0, 8'h03);
      expect_bytes(3, 1, 16'h5, 0);
      final_report();
   end
endmodule
`default_nettype wire

// [src/ncr_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ncr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW-1:0]    rd_d;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic [WIDTH-1:0] head_q;
   logic             valid_q;
   logic             push;
   logic             pop;
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   // head kept in flops so the outputs leave straight from a register
   assign out_valid = valid_q;
   assign out_data  = head_q;
   assign push      = in_valid & in_ready;
   assign pop       = valid_q & out_ready;
   always_comb begin
      rd_d = rd_q;
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         valid_q <= 1'b0;
         head_q  <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         valid_q <= (cnt_d != '0);
         // a word written into the next head slot is not in mem yet: bypass it
         head_q  <= (push && rd_d == wr_q) ? in_data : mem[rd_d];
      end
   end
endmodule
`default_nettype wire

// [src/ncr_host.sv]
// host controller driving the nand read, cache read and id sequences
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module ncr_host (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [2:0]  cmd_op,
   input  wire logic [27:0] cmd_addr,
   input  wire logic [7:0]  cmd_len,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [7:0]       rd_data,
   output logic             done_pulse,
   output logic             chip_en_n,
   output logic             cmd_latch,
   output logic             addr_latch,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic [7:0]       io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_n
);
   ////////////////////////////////////////////////////////////////////////////
   ncr_pkg::ncr_state_t state_q;
   logic [2:0]  op_q;
   logic [7:0]  addr_b_q [4];
   logic [2:0]  acnt_q;
   logic [2:0]  alen_q;
   logic [7:0]  rcnt_q;
   logic [3:0]  tcnt_q;
   logic        phase_q;
   logic [7:0]  io_q;
   logic        rb_s1_q;
   logic        rb_s2_q;
   logic [7:0]  io_s1_q;
   logic [7:0]  io_s2_q;
   logic        beat_end;
   ncr_stream_if fs ();

   // first command byte for an op
   function automatic logic [7:0] first_cmd(input logic [2:0] op);
      case (op)
         ncr_pkg::OP_CACHE_SEQ:  first_cmd = ncr_pkg::CMD_CACHE_SEQ;
         ncr_pkg::OP_CACHE_LAST: first_cmd = ncr_pkg::CMD_CACHE_LAST;
         ncr_pkg::OP_COL_CHANGE: first_cmd = ncr_pkg::CMD_COL_1ST;
         ncr_pkg::OP_ID_DEV,
         ncr_pkg::OP_ID_ALT:     first_cmd = ncr_pkg::CMD_ID;
         default:                first_cmd = ncr_pkg::CMD_READ_1ST;
      endcase
   endfunction

   // number of address cycles for an op
   function automatic logic [2:0] addr_cycles(input logic [2:0] op);
      case (op)
         ncr_pkg::OP_PAGE_READ,
         ncr_pkg::OP_CACHE_RAND: addr_cycles = 3'h4;
         ncr_pkg::OP_COL_CHANGE: addr_cycles = 3'h2;
         ncr_pkg::OP_ID_DEV,
         ncr_pkg::OP_ID_ALT:     addr_cycles = 3'h1;
         default:                addr_cycles = 3'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pins are outside this clock: two flops before use
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
         io_s1_q <= 8'h00;
         io_s2_q <= 8'h00;
      end else begin
         rb_s1_q <= ready_busy_n;
         rb_s2_q <= rb_s1_q;
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
      end
   end

   // each beat: low phase then high phase of a strobe
   assign beat_end = phase_q && (tcnt_q == ncr_pkg::STROBE_HIGH_CYC - 4'h1);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tcnt_q  <= 4'h0;
         phase_q <= 1'b0;
      end else if (state_q == ncr_pkg::ST_IDLE || state_q == ncr_pkg::ST_BUSY ||
                   state_q == ncr_pkg::ST_HOLD) begin
         tcnt_q  <= 4'h0;
         phase_q <= 1'b0;
      end else if (state_q == ncr_pkg::ST_BWAIT) begin
         tcnt_q  <= tcnt_q + 4'h1;
      end else if (!phase_q && tcnt_q == ncr_pkg::STROBE_LOW_CYC - 4'h1) begin
         tcnt_q  <= 4'h0;
         phase_q <= 1'b1;
      end else if (beat_end) begin
         tcnt_q  <= 4'h0;
         phase_q <= 1'b0;
      end else begin
         tcnt_q  <= tcnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q    <= ncr_pkg::ST_IDLE;
         op_q       <= ncr_pkg::OP_PAGE_READ;
         acnt_q     <= 3'h0;
         alen_q     <= 3'h0;
         rcnt_q     <= 8'h00;
         cmd_ready  <= 1'b0;
         done_pulse <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            addr_b_q[i] <= 8'h00;
         end
      end else begin
         done_pulse <= 1'b0;
         // ready stands in idle whatever valid does, and drops on the accepting edge
         cmd_ready  <= (state_q == ncr_pkg::ST_IDLE) && !(cmd_valid && cmd_ready);
         case (state_q)
            ncr_pkg::ST_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  op_q   <= cmd_op;
                  alen_q <= addr_cycles(cmd_op);
                  acnt_q <= 3'h0;
                  rcnt_q <= cmd_len;
                  addr_b_q[0] <= cmd_addr[7:0];
                  addr_b_q[1] <= {ncr_pkg::COL_HI_MASK, cmd_addr[11:8]};
                  addr_b_q[2] <= cmd_addr[19:12];
                  addr_b_q[3] <= cmd_addr[27:20];
                  if (cmd_op == ncr_pkg::OP_ID_DEV) begin
                     addr_b_q[0] <= ncr_pkg::ADDR_ID_DEV;
                  end else if (cmd_op == ncr_pkg::OP_ID_ALT) begin
                     addr_b_q[0] <= ncr_pkg::ADDR_ID_ALT;
                  end
                  // reads need no command: id and page data keep streaming
                  state_q <= (cmd_op == ncr_pkg::OP_DATA_READ) ?
                             ncr_pkg::ST_READ : ncr_pkg::ST_CMD;
               end
            end
            ncr_pkg::ST_CMD: begin
               if (beat_end) begin
                  state_q <= (alen_q != 3'h0) ? ncr_pkg::ST_ADDR : ncr_pkg::ST_BWAIT;
               end
            end
            ncr_pkg::ST_ADDR: begin
               if (beat_end) begin
                  acnt_q <= acnt_q + 3'h1;
                  if (acnt_q + 3'h1 == alen_q) begin
                     if (op_q == ncr_pkg::OP_ID_DEV || op_q == ncr_pkg::OP_ID_ALT) begin
                        state_q <= ncr_pkg::ST_READ;
                        rcnt_q  <= (op_q == ncr_pkg::OP_ID_DEV) ?
                                   {4'h0, ncr_pkg::ID_LEN_DEV} :
                                   {4'h0, ncr_pkg::ID_LEN_ALT};
                     end else begin
                        state_q <= ncr_pkg::ST_CMD2;
                     end
                  end
               end
            end
            ncr_pkg::ST_CMD2: begin
               if (beat_end) begin
                  // column change has no busy period
                  state_q <= (op_q == ncr_pkg::OP_COL_CHANGE) ?
                             ncr_pkg::ST_HOLD : ncr_pkg::ST_BWAIT;
               end
            end
            ncr_pkg::ST_BWAIT: begin
               // give the open-drain line time to fall before sampling
               if (tcnt_q == ncr_pkg::BUSY_WAIT_CYC) begin
                  state_q <= ncr_pkg::ST_BUSY;
               end
            end
            ncr_pkg::ST_BUSY: begin
               if (rb_s2_q) begin
                  state_q <= ncr_pkg::ST_HOLD;
               end
            end
            ncr_pkg::ST_READ: begin
               if (beat_end) begin
                  rcnt_q <= rcnt_q - 8'h01;
                  if (rcnt_q == 8'h01) begin
                     state_q <= ncr_pkg::ST_HOLD;
                  end
               end
            end
            ncr_pkg::ST_HOLD: begin
               done_pulse <= 1'b1;
               state_q    <= ncr_pkg::ST_IDLE;
            end
            default: state_q <= ncr_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive, all from flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         chip_en_n      <= 1'b1;
         cmd_latch      <= 1'b0;
         addr_latch     <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n  <= 1'b1;
         io_out         <= 8'h00;
         io_oe          <= 1'b0;
      end else begin
         chip_en_n      <= (state_q == ncr_pkg::ST_IDLE);
         cmd_latch      <= (state_q == ncr_pkg::ST_CMD) || (state_q == ncr_pkg::ST_CMD2);
         addr_latch     <= (state_q == ncr_pkg::ST_ADDR);
         io_oe          <= (state_q == ncr_pkg::ST_CMD) || (state_q == ncr_pkg::ST_CMD2) ||
                           (state_q == ncr_pkg::ST_ADDR);
         write_strobe_n <= !(!phase_q && (state_q == ncr_pkg::ST_CMD ||
                           state_q == ncr_pkg::ST_CMD2 || state_q == ncr_pkg::ST_ADDR));
         // no back-pressure: a full fifo drops bytes, so rd_ready must stay up
         read_strobe_n  <= !(!phase_q && state_q == ncr_pkg::ST_READ);
         case (state_q)
            ncr_pkg::ST_CMD:  io_out <= first_cmd(op_q);
            ncr_pkg::ST_ADDR: io_out <= addr_b_q[acnt_q[1:0]];
            ncr_pkg::ST_CMD2: io_out <= (op_q == ncr_pkg::OP_COL_CHANGE) ? ncr_pkg::CMD_COL_2ND :
                                        (op_q == ncr_pkg::OP_PAGE_READ) ? ncr_pkg::CMD_READ_2ND :
                                        ncr_pkg::CMD_CACHE_SEQ;
            default:          io_out <= io_out;
         endcase
      end
   end

   // byte captured at end of each read beat; stream lags pins by sync delay
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         io_q <= 8'h00;
      end else if (state_q == ncr_pkg::ST_READ && beat_end) begin
         io_q <= io_s2_q;
      end
   end

   logic push_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         push_q <= 1'b0;
      end else begin
         push_q <= (state_q == ncr_pkg::ST_READ) && beat_end;
      end
   end
   assign fs.valid = push_q;
   assign fs.data  = io_q;

   ncr_fifo #(
      .WIDTH (ncr_pkg::FIFO_WIDTH),
      .DEPTH (ncr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .reset     (reset),
      .in_valid  (fs.valid),
      .in_ready  (fs.ready),
      .in_data   (fs.data),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );
endmodule
`default_nettype wire

// [src/ncr_pkg.sv]
// constants and types for the nand cache read host controller
package ncr_pkg;
   localparam logic [7:0] CMD_READ_1ST   = 8'h00;
   localparam logic [7:0] CMD_READ_2ND   = 8'h30;
   localparam logic [7:0] CMD_CACHE_SEQ  = 8'h31;
   localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
   localparam logic [7:0] CMD_COL_1ST    = 8'h05;
   localparam logic [7:0] CMD_COL_2ND    = 8'hE0;
   localparam logic [7:0] CMD_ID         = 8'h90;
   localparam logic [7:0] ADDR_ID_DEV    = 8'h00;
   localparam logic [7:0] ADDR_ID_ALT    = 8'h20;
   localparam logic [3:0] ID_LEN_DEV     = 4'h5;
   localparam logic [3:0] ID_LEN_ALT     = 4'h4;
   localparam logic [3:0] COL_HI_MASK    = 4'h0;
   // op codes on the user command port
   localparam logic [2:0] OP_PAGE_READ   = 3'h0;
   localparam logic [2:0] OP_CACHE_SEQ   = 3'h1;
   localparam logic [2:0] OP_CACHE_RAND  = 3'h2;
   localparam logic [2:0] OP_CACHE_LAST  = 3'h3;
   localparam logic [2:0] OP_COL_CHANGE  = 3'h4;
   localparam logic [2:0] OP_ID_DEV      = 3'h5;
   localparam logic [2:0] OP_ID_ALT      = 3'h6;
   localparam logic [2:0] OP_DATA_READ   = 3'h7;
   // strobe phase lengths in ns, and cycles at 5 ns
   localparam int CLK_PERIOD_NS   = 5;
   localparam int STROBE_LOW_NS   = 15;
   localparam int STROBE_HIGH_NS  = 15;
   localparam logic [3:0] STROBE_LOW_CYC =
      4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_HIGH_CYC =
      4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] BUSY_WAIT_CYC = 4'h4;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 8;
   typedef enum logic [7:0] {
      ST_IDLE   = 8'b0000_0001,
      ST_CMD    = 8'b0000_0010,
      ST_ADDR   = 8'b0000_0100,
      ST_CMD2   = 8'b0000_1000,
      ST_BWAIT  = 8'b0001_0000,
      ST_BUSY   = 8'b0010_0000,
      ST_READ   = 8'b0100_0000,
      ST_HOLD   = 8'b1000_0000
   } ncr_state_t;
endpackage

// [src/ncr_stream_if.sv]
// valid/ready byte stream between the controller and its fifo
`timescale 1ns/10ps
`default_nettype none
interface ncr_stream_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire
